/* File: rtl/dhhs_pkg.sv */
// Constants for the main loop holdover, seamless switch and phase rate block
package dhhs_pkg;
    // ========================================================================
    // Register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] ADDR_HOLDOVER_METHOD = 8'h00;
    localparam logic [7:0] ADDR_OFFSET_WORD_LO = 8'h04;
    localparam logic [7:0] ADDR_OFFSET_WORD_HI = 8'h08;
    localparam logic [7:0] ADDR_SWITCH_BEHAVIOUR = 8'h0c;
    localparam logic [7:0] ADDR_LOOP_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_CUSTOM_PHASE_RATE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_PHASE_COMP = 8'h1c;

    // ========================================================================
    // Field positions
    localparam int HM_MAN_BIT = 0;
    localparam int HM_AUTO_BIT = 1;
    localparam int HM_HIST_LSB = 2;
    localparam int HM_AVG_LSB = 4;
    localparam int HM_READ_AVG_BIT = 6;
    localparam int SB_HITLESS_EN_BIT = 0;
    localparam int SB_FREEZE_BIT = 1;
    localparam int LL_RATE_SEL_LSB = 0;

    // ========================================================================
    // Reset values
    localparam logic HM_MAN_RST = 1'b0;
    localparam logic HM_AUTO_RST = 1'b1;
    localparam logic [1:0] HM_HIST_RST = 2'h0;
    localparam logic [1:0] HM_AVG_RST = 2'h1;
    localparam logic HM_READ_AVG_RST = 1'b0;
    localparam logic [2:0] RATE_SEL_RST = 3'h7;
    localparam logic [23:0] CUSTOM_RATE_RST = 24'h000000;

    // ========================================================================
    // History select codes
    typedef enum logic [1:0] {
        DHHS_HIST_NOW = 2'h0,
        DHHS_HIST_1S = 2'h1,
        DHHS_HIST_8S = 2'h2,
        DHHS_HIST_64S = 2'h3
    } dhhs_hist_t;

    // ========================================================================
    // Averaging filter: one sample per millisecond, shift sets bandwidth
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int CLK_MHZ = 200;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * CLK_MHZ;
    localparam int SECOND_US = 1000000;
    localparam int SECOND_CYCLES = SECOND_US * CLK_MHZ;
    localparam int AVG_FRAC = 24;
    localparam logic [4:0] SHIFT_BW_0M18 = 5'd20;
    localparam logic [4:0] SHIFT_BW_1M5 = 5'd17;
    localparam logic [4:0] SHIFT_BW_12M = 5'd14;
    localparam logic [4:0] SHIFT_BW_150M = 5'd10;
    localparam logic [4:0] SHIFT_PLAIN = 5'd17;

    // ========================================================================
    // Phase rate limits in ps per second, mapped to custom-limit LSB units
    localparam longint FULL_RATE_PS = 64'd1484361400;
    localparam longint RATE_SCALE = 64'd16777216;
    localparam longint RATE_61US_PS = 64'd61000000;
    localparam longint RATE_885NS_PS = 64'd885000;
    localparam longint RATE_7U5_PS = 64'd7500000;
    localparam longint RATE_1M4_PS = 64'd1400000000;
    localparam longint RATE_1NS_PS = 64'd1000;
    localparam longint RATE_5NS_PS = 64'd5000;
    localparam longint RATE_10NS_PS = 64'd10000;
    localparam logic [23:0] RATE_61US = 24'((RATE_61US_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam logic [23:0] RATE_885NS = 24'((RATE_885NS_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam logic [23:0] RATE_7U5 = 24'((RATE_7U5_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam logic [23:0] RATE_1M4 = 24'((RATE_1M4_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam logic [23:0] RATE_1NS = 24'((RATE_1NS_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam logic [23:0] RATE_5NS = 24'((RATE_5NS_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam logic [23:0] RATE_10NS = 24'((RATE_10NS_PS * RATE_SCALE) / FULL_RATE_PS);
    localparam longint RATE_MAX = 64'd16777216;
endpackage

/* File: rtl/dhhs_top.sv */
// Main loop holdover source select, seamless switching and phase rate limiter
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps

module dhhs_top #(
    parameter int SAMPLE_CYCLES = dhhs_pkg::SAMPLE_CYCLES,
    parameter int SECOND_CYCLES = dhhs_pkg::SECOND_CYCLES,
    parameter int PHASE_W = 32
) (
    input wire logic clk, // 200 MHz system clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic loop_locked, // Loop is in locked mode
    input wire logic in_holdover, // Loop is in holdover mode
    input wire logic in_freerun, // Loop is in free-run mode
    input wire logic dco_mode, // Host servo drives the oscillator
    input wire logic [3:0] ref_sel, // Selected reference index
    input wire logic signed [39:0] loop_freq, // Integral path frequency offset
    input wire logic [38:0] hard_limit, // Hard frequency limit magnitude
    input wire logic signed [PHASE_W-1:0] phase_meas, // Reference to output phase offset
    output logic signed [39:0] dco_freq, // Frequency offset to oscillator
    output logic signed [PHASE_W-1:0] phase_adj, // Phase offset injected at output
    output logic seamless_switch_event, // One-cycle event pulse
    output logic holdover_active // Holdover source in use
);
    // ========================================================================
    // Elaboration checks
    if (SECOND_CYCLES < dhhs_pkg::RATE_MAX) begin : g_chk_sec
        $error("SECOND_CYCLES must be at least 2^24 so one phase step per cycle suffices");
    end
    if (SAMPLE_CYCLES < 1 || PHASE_W < 8 || PHASE_W > 48) begin : g_chk_misc
        $error("Bad SAMPLE_CYCLES or PHASE_W");
    end

    // ========================================================================
    // Functions
    function automatic logic [4:0] bw_shift(input logic auto_on, input logic [1:0] avg_sel);
        logic [4:0] s;
        s = dhhs_pkg::SHIFT_PLAIN;
        if (auto_on) begin
            case (avg_sel)
                2'h0: s = dhhs_pkg::SHIFT_BW_0M18;
                2'h1: s = dhhs_pkg::SHIFT_BW_1M5;
                2'h2: s = dhhs_pkg::SHIFT_BW_12M;
                default: s = dhhs_pkg::SHIFT_BW_150M;
            endcase
        end
        return s;
    endfunction

    function automatic logic signed [39:0] clamp_f(input logic signed [39:0] v, input logic [38:0] lim);
        logic signed [39:0] hi;
        hi = $signed({1'b0, lim});
        if (v > hi) begin
            return hi;
        end else if (v < -hi) begin
            return -hi;
        end
        return v;
    endfunction

    function automatic logic [23:0] rate_of(input logic [2:0] sel, input logic [23:0] custom);
        logic [23:0] r;
        r = custom;
        case (sel)
            3'h0: r = dhhs_pkg::RATE_61US;
            3'h1: r = dhhs_pkg::RATE_885NS;
            3'h2: r = dhhs_pkg::RATE_7U5;
            3'h3: r = dhhs_pkg::RATE_1M4;
            3'h4: r = dhhs_pkg::RATE_1NS;
            3'h5: r = dhhs_pkg::RATE_5NS;
            3'h6: r = dhhs_pkg::RATE_10NS;
            default: r = custom;
        endcase
        return r;
    endfunction

    // ========================================================================
    // Configuration registers
    logic man_r, auto_r, read_avg_r, hitless_en_r, freeze_r;
    logic [1:0] hist_r, avg_sel_r;
    logic [39:0] word_r;
    logic [2:0] rate_sel_r;
    logic [23:0] custom_rate_r;
    logic wr_method, wr_lo, wr_hi, wr_switch, wr_limit, wr_custom;

    assign wr_method = reg_wr && reg_addr == dhhs_pkg::ADDR_HOLDOVER_METHOD;
    assign wr_lo = reg_wr && reg_addr == dhhs_pkg::ADDR_OFFSET_WORD_LO;
    assign wr_hi = reg_wr && reg_addr == dhhs_pkg::ADDR_OFFSET_WORD_HI;
    assign wr_switch = reg_wr && reg_addr == dhhs_pkg::ADDR_SWITCH_BEHAVIOUR;
    assign wr_limit = reg_wr && reg_addr == dhhs_pkg::ADDR_LOOP_LIMIT;
    assign wr_custom = reg_wr && reg_addr == dhhs_pkg::ADDR_CUSTOM_PHASE_RATE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            man_r <= dhhs_pkg::HM_MAN_RST;
            auto_r <= dhhs_pkg::HM_AUTO_RST;
            hist_r <= dhhs_pkg::HM_HIST_RST;
            avg_sel_r <= dhhs_pkg::HM_AVG_RST;
            read_avg_r <= dhhs_pkg::HM_READ_AVG_RST;
        end else if (wr_method) begin
            man_r <= reg_wdata[dhhs_pkg::HM_MAN_BIT];
            auto_r <= reg_wdata[dhhs_pkg::HM_AUTO_BIT];
            hist_r <= reg_wdata[dhhs_pkg::HM_HIST_LSB +: 2];
            avg_sel_r <= reg_wdata[dhhs_pkg::HM_AVG_LSB +: 2];
            read_avg_r <= reg_wdata[dhhs_pkg::HM_READ_AVG_BIT];
        end
    end

    // Word is signed two's complement; upper byte sits in its own register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word_r <= 40'h0;
        end else if (wr_lo) begin
            word_r[31:0] <= reg_wdata;
        end else if (wr_hi) begin
            word_r[39:32] <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hitless_en_r <= 1'b0;
            freeze_r <= 1'b0;
        end else if (wr_switch) begin
            hitless_en_r <= reg_wdata[dhhs_pkg::SB_HITLESS_EN_BIT];
            freeze_r <= reg_wdata[dhhs_pkg::SB_FREEZE_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rate_sel_r <= dhhs_pkg::RATE_SEL_RST;
            custom_rate_r <= dhhs_pkg::CUSTOM_RATE_RST;
        end else if (wr_limit) begin
            rate_sel_r <= reg_wdata[dhhs_pkg::LL_RATE_SEL_LSB +: 3];
        end else if (wr_custom) begin
            custom_rate_r <= reg_wdata[23:0];
        end
    end

    // ========================================================================
    // Averaging and history, running only while locked
    logic [31:0] sample_cnt_r;
    logic [31:0] sec_cnt_r;
    logic [5:0] sec_idx_r;
    logic sample_tick, sec_tick, tracking;
    logic signed [63:0] avg_acc_r;
    logic signed [63:0] avg_step;
    logic signed [39:0] avg_now;
    logic signed [39:0] hist1_r, hist8_r, hist8_pend_r, hist64_r, hist64_pend_r;

    assign tracking = loop_locked && !in_holdover;
    assign sample_tick = sample_cnt_r == 32'(SAMPLE_CYCLES - 1);
    assign sec_tick = sec_cnt_r == 32'(SECOND_CYCLES - 1);
    assign avg_now = avg_acc_r[dhhs_pkg::AVG_FRAC +: 40];
    assign avg_step = (($signed({{(24 - dhhs_pkg::AVG_FRAC){loop_freq[39]}}, loop_freq,
        {dhhs_pkg::AVG_FRAC{1'b0}}})) - avg_acc_r) >>> bw_shift(auto_r, avg_sel_r);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_cnt_r <= 32'h0;
            sec_cnt_r <= 32'h0;
            sec_idx_r <= 6'h0;
        end else begin
            sample_cnt_r <= sample_tick ? 32'h0 : sample_cnt_r + 32'h1;
            sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
            if (sec_tick) begin
                sec_idx_r <= sec_idx_r + 6'h1;
            end
        end
    end

    // Frozen outside lock, so the stored data is what the loop held before holdover
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avg_acc_r <= 64'sh0;
        end else if (tracking && sample_tick) begin
            avg_acc_r <= avg_acc_r + avg_step;
        end
    end

    // Snapshots: 1 s is a single stage; for 8 s and 64 s the older of two stages always lies at least N seconds back
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hist1_r <= 40'sh0;
            hist8_pend_r <= 40'sh0;
            hist8_r <= 40'sh0;
            hist64_pend_r <= 40'sh0;
            hist64_r <= 40'sh0;
        end else if (tracking && sec_tick) begin
            hist1_r <= avg_now;
            if (sec_idx_r[2:0] == 3'h7) begin
                hist8_pend_r <= avg_now;
                hist8_r <= hist8_pend_r;
            end
            if (sec_idx_r == 6'h3f) begin
                hist64_pend_r <= avg_now;
                hist64_r <= hist64_pend_r;
            end
        end
    end

    // ========================================================================
    // Holdover source and oscillator word
    logic signed [39:0] acquired;
    logic signed [39:0] freq_src;

    always_comb begin
        acquired = avg_now;
        if (auto_r) begin
            case (dhhs_pkg::dhhs_hist_t'(hist_r))
                dhhs_pkg::DHHS_HIST_NOW: acquired = avg_now;
                dhhs_pkg::DHHS_HIST_1S: acquired = hist1_r;
                dhhs_pkg::DHHS_HIST_8S: acquired = hist8_r;
                dhhs_pkg::DHHS_HIST_64S: acquired = hist64_r;
                default: acquired = avg_now;
            endcase
        end
    end

    // Word LSB weight depends on the applied offset; it is applied unscaled here
    always_comb begin
        if (dco_mode) begin
            freq_src = $signed(word_r);
        end else if (in_holdover) begin
            freq_src = man_r ? $signed(word_r) : acquired;
        end else begin
            freq_src = loop_freq;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dco_freq <= 40'sh0;
            holdover_active <= 1'b0;
        end else begin
            dco_freq <= clamp_f(freq_src, hard_limit);
            holdover_active <= in_holdover && !dco_mode;
        end
    end

    // ========================================================================
    // Seamless switching
    logic [3:0] ref_prev_r;
    logic idle_prev_r;
    logic ref_changed, idle_exit, hs_fire;
    logic signed [PHASE_W-1:0] comp_r;

    assign ref_changed = ref_sel != ref_prev_r;
    assign idle_exit = idle_prev_r && !(in_holdover || in_freerun);
    assign hs_fire = hitless_en_r && !freeze_r && (ref_changed || idle_exit);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_prev_r <= 4'h0;
            idle_prev_r <= 1'b1;
            seamless_switch_event <= 1'b0;
        end else begin
            ref_prev_r <= ref_sel;
            idle_prev_r <= in_holdover || in_freerun;
            seamless_switch_event <= hs_fire;
        end
    end

    // Measured offset is taken in the event cycle so the output never sees the step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comp_r <= '0;
        end else if (hs_fire) begin
            comp_r <= phase_meas;
        end
    end

    // ========================================================================
    // Phase rate limiter
    logic [31:0] rate_acc_r;
    logic [31:0] rate_sum;
    logic rate_step;
    logic signed [PHASE_W-1:0] phase_target;

    assign rate_sum = rate_acc_r + {8'h0, rate_of(rate_sel_r, custom_rate_r)};
    assign rate_step = rate_sum >= 32'(SECOND_CYCLES);
    assign phase_target = hitless_en_r ? comp_r : '0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rate_acc_r <= 32'h0;
        end else begin
            rate_acc_r <= rate_step ? rate_sum - 32'(SECOND_CYCLES) : rate_sum;
        end
    end

    // One fine step at most per overflow; the injected compensation bypasses it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_adj <= '0;
        end else if (hs_fire) begin
            phase_adj <= phase_meas;
        end else if (rate_step && phase_adj > phase_target) begin
            phase_adj <= phase_adj - 1'b1;
        end else if (rate_step && phase_adj < phase_target) begin
            phase_adj <= phase_adj + 1'b1;
        end
    end

    // ========================================================================
    // Register read port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                dhhs_pkg::ADDR_HOLDOVER_METHOD: reg_rdata <= {25'h0, read_avg_r, avg_sel_r, hist_r, auto_r, man_r};
                dhhs_pkg::ADDR_OFFSET_WORD_LO: reg_rdata <= read_avg_r ? acquired[31:0] : word_r[31:0];
                dhhs_pkg::ADDR_OFFSET_WORD_HI: reg_rdata <= {24'h0, read_avg_r ? acquired[39:32] : word_r[39:32]};
                dhhs_pkg::ADDR_SWITCH_BEHAVIOUR: reg_rdata <= {30'h0, freeze_r, hitless_en_r};
                dhhs_pkg::ADDR_LOOP_LIMIT: reg_rdata <= {29'h0, rate_sel_r};
                dhhs_pkg::ADDR_CUSTOM_PHASE_RATE: reg_rdata <= {8'h0, custom_rate_r};
                dhhs_pkg::ADDR_STATUS: reg_rdata <= {29'h0, tracking, holdover_active, seamless_switch_event};
                dhhs_pkg::ADDR_PHASE_COMP: reg_rdata <= 32'(comp_r);
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ========================================================================
    // Assertions
    sequence ref_change_s;
        hitless_en_r && !freeze_r && ref_sel != ref_prev_r;
    endsequence

    sequence idle_leave_s;
        hitless_en_r && !freeze_r && idle_prev_r && !in_holdover && !in_freerun;
    endsequence

    property hs_inject_p;
        @(posedge clk) disable iff (!resetn)
        (ref_change_s or idle_leave_s) |=> seamless_switch_event && phase_adj == $past(phase_meas);
    endproperty
    hs_inject_a: assert property (hs_inject_p) else $error("Switch event did not inject phase");

    freeze_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
        freeze_r && $past(freeze_r) |-> !seamless_switch_event && $stable(comp_r))
        else $error("Frozen switch still reacted");

    freq_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
        dco_freq <= $signed({1'b0, $past(hard_limit)}) && dco_freq >= -$signed({1'b0, $past(hard_limit)}))
        else $error("Oscillator word beyond hard limit");

    manual_word_a: assert property (@(posedge clk) disable iff (!resetn)
        in_holdover && man_r && !dco_mode |=> dco_freq == clamp_f($signed($past(word_r)), $past(hard_limit)))
        else $error("Manual holdover word not applied");

    holdover_hist_a: assert property (@(posedge clk) disable iff (!resetn)
        in_holdover && !man_r && auto_r && hist_r == 2'h3 && !dco_mode
        |=> dco_freq == clamp_f($past(hist64_r), $past(hard_limit)))
        else $error("64 second history not used in holdover");

    avg_frozen_a: assert property (@(posedge clk) disable iff (!resetn)
        !tracking [*2] |-> $stable(avg_acc_r) && $stable(hist1_r) && $stable(hist8_r) && $stable(hist64_r))
        else $error("Averages moved outside lock");

    slope_step_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(hs_fire) && !$past(rate_step) |-> $stable(phase_adj))
        else $error("Phase moved without a rate step");

    drift_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        !hitless_en_r && !hs_fire && phase_adj > 0 && rate_step |=> phase_adj == $past(phase_adj) - 1)
        else $error("Disabled switching did not drift toward zero");

    readback_a: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == dhhs_pkg::ADDR_OFFSET_WORD_LO
        |=> reg_rdata == ($past(read_avg_r) ? $past(acquired[31:0]) : $past(word_r[31:0])))
        else $error("Offset word readback source wrong");
endmodule

/* File: tb/dhhs_loop_model.sv */
// Behavioural model of the loop mode source and reference selector
`timescale 1ns/1ps
module dhhs_loop_model (
    input wire logic [1:0] mode_cmd, // 0 locked, 1 holdover, 2 free-run
    input wire logic [3:0] ref_cmd, // Requested reference
    input wire logic signed [39:0] freq_cmd, // Integral path value
    input wire logic signed [31:0] phase_cmd, // Measured phase offset
    output logic loop_locked, // Locked flag
    output logic in_holdover, // Holdover flag
    output logic in_freerun, // Free-run flag
    output logic [3:0] ref_sel, // Selected reference
    output logic signed [39:0] loop_freq, // Integral path value
    output logic signed [31:0] phase_meas // Measured phase offset
);
    // ========================================================================
    // Mode flags are decoded from one code so two modes never overlap
    assign loop_locked = (mode_cmd == 2'h0);
    assign in_holdover = (mode_cmd == 2'h1);
    assign in_freerun = (mode_cmd == 2'h2);
    assign ref_sel = ref_cmd;
    assign loop_freq = freq_cmd;
    // References stand at 8 kHz or above, so each reading is fresh
    assign phase_meas = phase_cmd;
endmodule

/* File: tb/test_dhhs_top.sv */
// Self-checking bench for the holdover, switch and phase rate block
`timescale 1ns/1ps
module test_dhhs_top;
    // ========================================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [1:0] mode_cmd = 2'h0;
    logic [3:0] ref_cmd = 4'h0;
    logic signed [39:0] freq_cmd = 40'sh0;
    logic signed [31:0] phase_cmd = 32'sh0;
    logic dco_mode = 1'b0;
    logic [38:0] hard_limit = 39'h7fffffffff;
    logic loop_locked, in_holdover, in_freerun, seamless_switch_event, holdover_active;
    logic [3:0] ref_sel;
    logic signed [39:0] loop_freq, dco_freq;
    logic signed [31:0] phase_meas, phase_adj;
    int failures = 0;
    int checked = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    dhhs_loop_model dhhs_loop_model_inst (.mode_cmd(mode_cmd), .ref_cmd(ref_cmd), .freq_cmd(freq_cmd),
        .phase_cmd(phase_cmd), .loop_locked(loop_locked), .in_holdover(in_holdover), .in_freerun(in_freerun),
        .ref_sel(ref_sel), .loop_freq(loop_freq), .phase_meas(phase_meas));
    // Short second keeps the rate limiter visible within a short run
    dhhs_top #(.SAMPLE_CYCLES(4), .SECOND_CYCLES(16777216), .PHASE_W(32)) dhhs_top_inst (.clk(clk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .loop_locked(loop_locked), .in_holdover(in_holdover), .in_freerun(in_freerun),
        .dco_mode(dco_mode), .ref_sel(ref_sel), .loop_freq(loop_freq), .hard_limit(hard_limit),
        .phase_meas(phase_meas), .dco_freq(dco_freq), .phase_adj(phase_adj),
        .seamless_switch_event(seamless_switch_event), .holdover_active(holdover_active));
    // ========================================================================
    // Bus cycles, comparison and verdict
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic compare(input string name, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Let the design run for n rising edges, then look at the next falling edge once it settles
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic close_out;
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(5 * 20000);
        failures++;
        close_out();
    end
    // ========================================================================
    // Test sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(dhhs_pkg::ADDR_HOLDOVER_METHOD, rv);
        compare("method", 40'(rv), 40'h12);
        rd_reg(dhhs_pkg::ADDR_LOOP_LIMIT, rv);
        compare("rate_sel", 40'(rv), 40'h7);
        rd_reg(dhhs_pkg::ADDR_CUSTOM_PHASE_RATE, rv);
        compare("custom", 40'(rv), 40'h0);
        wr_reg(dhhs_pkg::ADDR_CUSTOM_PHASE_RATE, 32'hffabcdef);
        rd_reg(dhhs_pkg::ADDR_CUSTOM_PHASE_RATE, rv);
        compare("custom_w", 40'(rv), 40'habcdef);
        // Back to a zero limit so the later phase checks start from a still limiter
        wr_reg(dhhs_pkg::ADDR_CUSTOM_PHASE_RATE, 32'h0);
        rd_reg(8'h20, rv);
        compare("unmapped", 40'(rv), 40'h0);
        wr_reg(dhhs_pkg::ADDR_OFFSET_WORD_LO, 32'h89abcdef);
        wr_reg(dhhs_pkg::ADDR_OFFSET_WORD_HI, 32'h000000f1);
        rd_reg(dhhs_pkg::ADDR_OFFSET_WORD_HI, rv);
        compare("word_hi", 40'(rv), 40'hf1);
        rd_reg(dhhs_pkg::ADDR_OFFSET_WORD_LO, rv);
        compare("word_lo", 40'(rv), 40'h89abcdef);
        wr_reg(dhhs_pkg::ADDR_HOLDOVER_METHOD, 32'h13);
        @(posedge clk) mode_cmd <= 2'h1;
        freq_cmd <= 40'sd777;
        settle(2);
        compare("manual", dco_freq, 40'hf189abcdef);
        compare("ho_active", 40'(holdover_active), 40'h1);
        // Auto, 64 s history, read back the acquired value instead of the word
        wr_reg(dhhs_pkg::ADDR_HOLDOVER_METHOD, 32'h5e);
        settle(1);
        compare("hist64", dco_freq, 40'h0);
        rd_reg(dhhs_pkg::ADDR_OFFSET_WORD_LO, rv);
        compare("acq_lo", 40'(rv), 40'h0);
        rd_reg(dhhs_pkg::ADDR_STATUS, rv);
        compare("status", 40'(rv), 40'h2);
        @(posedge clk) mode_cmd <= 2'h0;
        dco_mode <= 1'b1;
        settle(2);
        compare("dco", dco_freq, 40'hf189abcdef);
        @(posedge clk) dco_mode <= 1'b0;
        hard_limit <= 39'd1000;
        freq_cmd <= 40'sd5000;
        settle(1);
        compare("clamp_pos", dco_freq, 40'sd1000);
        @(posedge clk) freq_cmd <= -40'sd5000;
        settle(1);
        compare("clamp_neg", dco_freq, -40'sd1000);
        wr_reg(dhhs_pkg::ADDR_SWITCH_BEHAVIOUR, 32'h1);
        @(posedge clk) ref_cmd <= 4'h5;
        phase_cmd <= 32'sd100;
        settle(1);
        compare("ev_ref", 40'(seamless_switch_event), 40'h1);
        compare("adj_ref", 40'(phase_adj), 40'(32'sd100));
        settle(0);
        compare("ev_pulse", 40'(seamless_switch_event), 40'h0);
        @(posedge clk) mode_cmd <= 2'h1;
        phase_cmd <= 32'sd200;
        settle(3);
        @(posedge clk) mode_cmd <= 2'h0;
        settle(1);
        compare("ev_exit", 40'(seamless_switch_event), 40'h1);
        compare("adj_exit", 40'(phase_adj), 40'(32'sd200));
        @(posedge clk) mode_cmd <= 2'h2;
        phase_cmd <= 32'sd250;
        settle(3);
        @(posedge clk) mode_cmd <= 2'h0;
        settle(1);
        compare("ev_freerun", 40'(seamless_switch_event), 40'h1);
        compare("adj_freerun", 40'(phase_adj), 40'(32'sd250));
        wr_reg(dhhs_pkg::ADDR_SWITCH_BEHAVIOUR, 32'h3);
        @(posedge clk) ref_cmd <= 4'h6;
        phase_cmd <= 32'sd300;
        settle(1);
        compare("ev_frozen", 40'(seamless_switch_event), 40'h0);
        compare("adj_frozen", 40'(phase_adj), 40'(32'sd250));
        rd_reg(dhhs_pkg::ADDR_PHASE_COMP, rv);
        compare("comp_held", 40'(rv), 40'hfa);
        wr_reg(dhhs_pkg::ADDR_SWITCH_BEHAVIOUR, 32'h0);
        @(posedge clk) ref_cmd <= 4'h7;
        settle(20);
        compare("ev_off", 40'(seamless_switch_event), 40'h0);
        compare("adj_zero_rate", 40'(phase_adj), 40'(32'sd250));
        wr_reg(dhhs_pkg::ADDR_LOOP_LIMIT, 32'h3);
        settle(400);
        compare("adj_drift", 40'(phase_adj), 40'h0);
        close_out();
    end
endmodule
